// ---- cpu_rst_consts.vh ----
// Purpose: shared constants for the reset, timing and power mode control block
// Assumes: special register bus with 8-bit address and data
// Notes: offsets are the special register addresses
`ifndef CPU_RST_CONSTS_VH
`define CPU_RST_CONSTS_VH
`define ADDR_POWER_CONTROL 8'h87
`define ADDR_AUX_CONTROL 8'hA2
`define ADDR_STARTUP_STATUS 8'hA3
`define ADDR_BOOT_CONFIG 8'hF1
`define RST_POWER_CONTROL 8'h00
`define RST_AUX_CONTROL 8'h00
`define RST_BOOT_CONFIG 8'h00
`define RST_PORT 8'hFF
`define BIT_IDLE 0
`define BIT_POWERDOWN 1
`define BIT_GF0 2
`define BIT_GF1 3
`define BIT_WLE 4
`define BIT_BAUD_DOUBLE 7
`define BIT_SOFT_RESTART 5
`define BIT_WDOG_BOOT_SEL 1
`define BIT_BOOT_RELOAD 2
`define POWER_CONTROL_WMASK 8'h9F
`define SRC_EXTERNAL 3'h0
`define SRC_SOFTWARE 3'h1
`define SRC_WATCHDOG 3'h2
`define STATES_PER_CYCLE 2'h3
`define WLE_CYCLES 4'hD
`define RESTART_DELAY 2'h3
`define FETCHES_SKIPPED 3'h5
`endif

// ---- reset_sync3.v ----
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input may change at any time
// Notes: output follows once stages two and three agree
`timescale 1ns/1ns
module reset_sync3 (
	input wire clk_i, // core clock
	input wire rst_i, // async reset
	input wire d_i, // raw level
	output reg q_o // filtered level
);
	reg s1_r;
	reg s2_r;
	reg s3_r;
	// s1 feeds only s2 so metastability never reaches logic
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			q_o <= 1'b0;
		end
		else
		begin
			s1_r <= d_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r)
				q_o <= s3_r;
		end
	end
endmodule

// ---- cpu_reset_power_mode_control.v ----
// Purpose: reset, machine-cycle timing and power mode control for the core
// Assumes: single 20 MHz clock; external reset and wake inputs are asynchronous
// Notes: special registers reached by the core's own 8-bit register port
`timescale 1ns/1ns
`include "cpu_rst_consts.vh"
module cpu_reset_power_mode_control (
	input wire clk_i, // core clock, 20 MHz
	input wire rst_i, // power-on reset, async high
	input wire async_external_reset_in_i, // external reset pin, high active
	input wire watchdog_reset_signal_n_i, // watchdog timeout, low active
	input wire watchdog_enabled_i, // watchdog running
	input wire boot_done_i, // boot loader finished copy
	input wire irq_pending_i, // any enabled interrupt pending
	input wire ext_irq_low_n_i, // enabled low-level external interrupt pin
	input wire external_code_i, // code memory is external
	input wire external_data_move_i, // current instruction is an external data move
	input wire insn_need_i, // next instruction needs another fetched byte
	input wire [7:0] sfr_addr_i, // special register address
	input wire [7:0] sfr_wdata_i, // write data
	input wire sfr_wr_i, // write strobe
	output reg [7:0] sfr_rdata_o, // read data
	output reg [1:0] state_o, // current state within machine cycle
	output reg fetch_o, // code fetch in this state
	output reg fetch_advance_o, // fetch counter increments
	output reg program_read_strobe_n_o, // program read strobe, low active
	output reg core_run_o, // core executes
	output reg core_restart_o, // pulse: restart core at address zero
	output reg sfr_defaults_o, // pulse: load special registers with defaults; boot configuration only on a reload
	output reg boot_reload_o, // boot loader reload input
	output reg boot_active_o, // boot loader holds core
	output reg [7:0] port_init_o, // port register value after reset
	output reg periph_run_o, // timers and serial units run
	output reg baud_doubler_bit_o, // baud rate doubled
	output reg watchdog_load_enable_o, // watchdog reload allowed
	output reg [2:0] startup_source_field_o // last restart cause
);
	localparam ST_BOOT = 2'h0;
	localparam ST_RUN = 2'h1;
	localparam ST_IDLE = 2'h2;
	localparam ST_PDOWN = 2'h3;

	wire ext_rst_s;
	wire wdog_s;
	wire wake_s;
	reg [1:0] mode_r;
	reg [1:0] state_r;
	reg mc_second_r;
	reg [7:0] power_control_r;
	reg [7:0] aux_r;
	reg [7:0] boot_configuration_r;
	reg [2:0] src_r;
	reg [3:0] wle_cnt_r;
	reg [1:0] delay_r;
	reg ext_rst_d_r;
	reg wdog_d_r;
	reg [2:0] skip_r;
	reg restart_nxt;
	reg reload_nxt;
	reg fetch_nxt;

	// external pins cross into clk domain through three flops
	reset_sync3 u_sync_rst (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(async_external_reset_in_i),
		.q_o(ext_rst_s)
	);
	reset_sync3 u_sync_wdog (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(~watchdog_reset_signal_n_i),
		.q_o(wdog_s)
	);
	reset_sync3 u_sync_wake (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(~ext_irq_low_n_i),
		.q_o(wake_s)
	);

	// register select decode shared by read and write paths
	function sel;
		input [7:0] a;
		input [7:0] off;
		begin
			sel = (a == off);
		end
	endfunction

	wire ext_rst_rise = ext_rst_s & ~ext_rst_d_r;
	wire wdog_rise = wdog_s & ~wdog_d_r;
	wire wr_power_control = sfr_wr_i & sel(sfr_addr_i, `ADDR_POWER_CONTROL);
	wire wr_aux = sfr_wr_i & sel(sfr_addr_i, `ADDR_AUX_CONTROL);
	wire wr_boot_configuration = sfr_wr_i & sel(sfr_addr_i, `ADDR_BOOT_CONFIG);
	wire soft_rst = wr_aux & sfr_wdata_i[`BIT_SOFT_RESTART];
	wire cycle_end = (state_r == 2'h2);
	wire running = (mode_r == ST_RUN) && (delay_r == 2'h0);

	// restart and boot decisions; external reset always reloads
	always @*
	begin
		restart_nxt = 1'b0;
		reload_nxt = 1'b0;
		if (wdog_rise)
		begin
			if (boot_configuration_r[`BIT_WDOG_BOOT_SEL])
				reload_nxt = 1'b1;
			else
				restart_nxt = 1'b1;
		end
		if (soft_rst)
			restart_nxt = 1'b1;
		// the reload bit is a trigger, so its write is a full reload with defaults
		if (wr_boot_configuration && sfr_wdata_i[`BIT_BOOT_RELOAD])
			reload_nxt = 1'b1;
		if (ext_rst_rise)
		begin
			reload_nxt = 1'b1;
			restart_nxt = 1'b0;
		end
	end

	// mode, reset sources and special registers
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			mode_r <= ST_BOOT;
			power_control_r <= `RST_POWER_CONTROL;
			aux_r <= `RST_AUX_CONTROL;
			boot_configuration_r <= `RST_BOOT_CONFIG;
			src_r <= `SRC_EXTERNAL;
			wle_cnt_r <= 4'h0;
			delay_r <= 2'h0;
			ext_rst_d_r <= 1'b0;
			wdog_d_r <= 1'b0;
			core_restart_o <= 1'b0;
			sfr_defaults_o <= 1'b0;
			boot_reload_o <= 1'b0;
		end
		else
		begin
			ext_rst_d_r <= ext_rst_s;
			wdog_d_r <= wdog_s;
			core_restart_o <= 1'b0;
			sfr_defaults_o <= 1'b0;
			boot_reload_o <= 1'b0;
			if (delay_r != 2'h0)
				delay_r <= delay_r - 2'h1;
			if (reload_nxt || restart_nxt)
			begin
				// defaults loaded, RAM untouched; boot_configuration keeps its selection bit on a restart but is cleared on a reload
				power_control_r <= `RST_POWER_CONTROL;
				aux_r <= `RST_AUX_CONTROL;
				wle_cnt_r <= 4'h0;
				sfr_defaults_o <= 1'b1;
				if (ext_rst_rise)
					src_r <= `SRC_EXTERNAL;
				else if (wdog_rise)
					src_r <= `SRC_WATCHDOG;
				else if (soft_rst)
					src_r <= `SRC_SOFTWARE;
				if (reload_nxt)
				begin
					boot_configuration_r <= `RST_BOOT_CONFIG;
					boot_reload_o <= 1'b1;
					mode_r <= ST_BOOT;
				end
				else
				begin
					core_restart_o <= 1'b1;
					delay_r <= `RESTART_DELAY;
					mode_r <= ST_RUN;
				end
			end
			else
			begin
				if (wr_boot_configuration)
					boot_configuration_r <= sfr_wdata_i;
				if (wr_aux)
					aux_r <= sfr_wdata_i & ~(8'h01 << `BIT_SOFT_RESTART);
				case (mode_r)
					ST_BOOT:
					begin
						if (boot_done_i)
						begin
							mode_r <= ST_RUN;
							core_restart_o <= 1'b1;
							delay_r <= `RESTART_DELAY;
						end
					end
					ST_RUN:
					begin
						if (wr_power_control)
						begin
							power_control_r <= (sfr_wdata_i & `POWER_CONTROL_WMASK);
							if (watchdog_enabled_i)
								power_control_r[1:0] <= 2'h0;
							else if (sfr_wdata_i[`BIT_POWERDOWN])
							begin
								power_control_r[`BIT_IDLE] <= 1'b0;
								mode_r <= ST_PDOWN;
							end
							else if (sfr_wdata_i[`BIT_IDLE])
								mode_r <= ST_IDLE;
							if (sfr_wdata_i[`BIT_WLE])
								wle_cnt_r <= `WLE_CYCLES;
						end
					end
					ST_IDLE:
					begin
						if (irq_pending_i)
						begin
							power_control_r[`BIT_IDLE] <= 1'b0;
							mode_r <= ST_RUN;
						end
					end
					ST_PDOWN:
					begin
						if (wake_s)
						begin
							power_control_r[`BIT_POWERDOWN] <= 1'b0;
							mode_r <= ST_RUN;
						end
					end
					default:
						mode_r <= ST_BOOT;
				endcase
				// load enable drops after thirteen machine cycles
				if (!(wr_power_control && sfr_wdata_i[`BIT_WLE]) && (wle_cnt_r != 4'h0) && cycle_end)
				begin
					wle_cnt_r <= wle_cnt_r - 4'h1;
					if (wle_cnt_r == 4'h1)
						power_control_r[`BIT_WLE] <= 1'b0;
				end
			end
		end
	end

	// three-state machine cycle; forced back to state zero while the core is stopped
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_r <= 2'h0;
			mc_second_r <= 1'b0;
			skip_r <= 3'h0;
		end
		else if (!running)
		begin
			state_r <= 2'h0;
			mc_second_r <= 1'b0;
			skip_r <= 3'h0;
		end
		else
		begin
			if (state_r == (`STATES_PER_CYCLE - 2'h1))
				state_r <= 2'h0;
			else
				state_r <= state_r + 2'h1;
			if (cycle_end)
				mc_second_r <= external_data_move_i & ~mc_second_r;
			if (state_r == 2'h0 && external_data_move_i && !mc_second_r)
				skip_r <= `FETCHES_SKIPPED;
			else if (skip_r != 3'h0)
				skip_r <= skip_r - 3'h1;
		end
	end

	// fetch once per state except the five states a data move takes
	always @*
	begin
		fetch_nxt = running & (skip_r == 3'h0);
		if (running && state_r == 2'h0 && external_data_move_i && !mc_second_r)
			fetch_nxt = 1'b1;
		else if (running && external_data_move_i && !mc_second_r)
			fetch_nxt = 1'b0;
	end

	// registered outputs; strobe level depends on the stop mode
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_o <= 2'h0;
			fetch_o <= 1'b0;
			fetch_advance_o <= 1'b0;
			program_read_strobe_n_o <= 1'b1;
			core_run_o <= 1'b0;
			boot_active_o <= 1'b1;
			port_init_o <= `RST_PORT;
			periph_run_o <= 1'b1;
			baud_doubler_bit_o <= 1'b0;
			watchdog_load_enable_o <= 1'b0;
			startup_source_field_o <= `SRC_EXTERNAL;
			sfr_rdata_o <= 8'h00;
		end
		else
		begin
			state_o <= state_r;
			fetch_o <= fetch_nxt;
			fetch_advance_o <= fetch_nxt & insn_need_i;
			if (mode_r == ST_PDOWN)
				program_read_strobe_n_o <= 1'b0;
			else if (mode_r == ST_IDLE)
				program_read_strobe_n_o <= 1'b1;
			else
				program_read_strobe_n_o <= ~(fetch_nxt & external_code_i);
			core_run_o <= running;
			boot_active_o <= (mode_r == ST_BOOT);
			port_init_o <= `RST_PORT;
			periph_run_o <= (mode_r != ST_PDOWN);
			baud_doubler_bit_o <= power_control_r[`BIT_BAUD_DOUBLE];
			watchdog_load_enable_o <= power_control_r[`BIT_WLE];
			startup_source_field_o <= src_r;
			if (sel(sfr_addr_i, `ADDR_POWER_CONTROL))
				sfr_rdata_o <= power_control_r;
			else if (sel(sfr_addr_i, `ADDR_AUX_CONTROL))
				sfr_rdata_o <= aux_r;
			else if (sel(sfr_addr_i, `ADDR_STARTUP_STATUS))
				sfr_rdata_o <= {5'h00, src_r};
			else if (sel(sfr_addr_i, `ADDR_BOOT_CONFIG))
				sfr_rdata_o <= boot_configuration_r;
			else
				sfr_rdata_o <= 8'h00;
		end
	end
endmodule

// ---- cpu_reset_power_mode_control_asserts.sv ----
// Purpose: port checks for the reset and power mode block
// Assumes: one clock domain, bound to the block
// Notes: latencies follow the hand-over figures
`timescale 1ns/1ns
`include "cpu_rst_consts.vh"
module cpu_reset_power_mode_control_asserts (
	input wire clk_i, // clock
	input wire rst_i, // reset
	input wire watchdog_enabled_i, // watchdog on
	input wire [7:0] sfr_addr_i, // address
	input wire [7:0] sfr_wdata_i, // write data
	input wire sfr_wr_i, // write
	input wire [1:0] state_o, // state
	input wire fetch_o, // fetch
	input wire fetch_advance_o, // advance
	input wire program_read_strobe_n_o, // strobe
	input wire core_run_o, // run
	input wire core_restart_o, // restart
	input wire sfr_defaults_o, // defaults
	input wire boot_reload_o, // reload
	input wire boot_active_o, // boot hold
	input wire periph_run_o, // peripherals
	input wire watchdog_load_enable_o // load enable
);
	// writes only count while the core runs
	wire mode_wr = sfr_wr_i && core_run_o && sfr_addr_i == `ADDR_POWER_CONTROL;
	wire aux_wr = sfr_wr_i && core_run_o && sfr_addr_i == `ADDR_AUX_CONTROL;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	property p_state_cycle;
		(core_run_o && state_o != 2'h2) ##1 core_run_o |-> state_o == $past(state_o) + 2'h1;
	endproperty
	a_state_cycle: assert property (p_state_cycle) else $error("state order broken");
	property p_fetch_advance;
		fetch_advance_o |-> fetch_o;
	endproperty
	a_fetch_advance: assert property (p_fetch_advance) else $error("advance without fetch");
	property p_idle_entry;
		mode_wr && sfr_wdata_i == 8'h01 && !watchdog_enabled_i
			|-> ##[1:3] program_read_strobe_n_o && periph_run_o && !core_run_o;
	endproperty
	a_idle_entry: assert property (p_idle_entry) else $error("idle not entered");
	property p_pd_entry;
		mode_wr && sfr_wdata_i[1:0] == 2'h3 && !watchdog_enabled_i
			|-> ##[1:3] !program_read_strobe_n_o && !periph_run_o && !core_run_o;
	endproperty
	a_pd_entry: assert property (p_pd_entry) else $error("power-down not entered");
	property p_refuse;
		mode_wr && watchdog_enabled_i |=> core_run_o [*3];
	endproperty
	a_refuse: assert property (p_refuse) else $error("mode taken with watchdog on");
	property p_soft;
		aux_wr && sfr_wdata_i[5] |=> core_restart_o && sfr_defaults_o && !boot_reload_o;
	endproperty
	a_soft: assert property (p_soft) else $error("soft restart missing");
	property p_restart;
		core_restart_o ##1 !boot_active_o |-> !core_run_o [*3] ##1 core_run_o;
	endproperty
	a_restart: assert property (p_restart) else $error("restart delay wrong");
	property p_wle;
		$rose(watchdog_load_enable_o) |-> ##35 watchdog_load_enable_o ##[1:7] !watchdog_load_enable_o;
	endproperty
	a_wle: assert property (p_wle) else $error("load enable time wrong");
	c_idle: cover property (mode_wr && sfr_wdata_i == 8'h01);
	c_restart: cover property (core_restart_o);
	c_reload: cover property (boot_reload_o);
endmodule
bind cpu_reset_power_mode_control cpu_reset_power_mode_control_asserts u_asserts (
	.clk_i(clk_i), .rst_i(rst_i), .watchdog_enabled_i(watchdog_enabled_i),
	.sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i),
	.state_o(state_o), .fetch_o(fetch_o), .fetch_advance_o(fetch_advance_o),
	.program_read_strobe_n_o(program_read_strobe_n_o), .core_run_o(core_run_o),
	.core_restart_o(core_restart_o), .sfr_defaults_o(sfr_defaults_o),
	.boot_reload_o(boot_reload_o), .boot_active_o(boot_active_o),
	.periph_run_o(periph_run_o), .watchdog_load_enable_o(watchdog_load_enable_o)
);

// ---- boot_partner_model.sv ----
// Purpose: boot loader stand-in that copies for a set number of cycles
// Assumes: the block raises its boot hold for each reload
// Notes: done falls as soon as the hold is dropped
`timescale 1ns/1ns
module boot_partner_model (
	input wire clk_i, // core clock
	input wire boot_active_i, // block waits for the copy
	input wire [3:0] copy_len_i, // copy length in cycles
	output reg boot_done_o // copy finished
);
	reg [3:0] count_r = 4'h0;
	initial boot_done_o = 1'b0;
	// a fresh hold restarts the copy, so a reload after the hold has dropped never ends early; one during a hold keeps counting
	always @(posedge clk_i)
	begin
		if (!boot_active_i)
		begin
			count_r <= 4'h0;
			boot_done_o <= 1'b0;
		end
		else if (count_r != copy_len_i)
			count_r <= count_r + 4'h1;
		else
			boot_done_o <= 1'b1;
	end
endmodule

// ---- cpu_reset_power_mode_control_test.sv ----
// Purpose: self-checking bench for the reset and power mode block
// Assumes: inputs change at the falling edge
// Notes: boot copies are prompt at power-on and slow elsewhere
`timescale 1ns/1ns
`include "cpu_rst_consts.vh"
module cpu_reset_power_mode_control_test;
	reg clk_i = 1'b0, rst_i = 1'b1, ext_rst = 1'b0, wdog_n = 1'b1, wdog_en = 1'b0;
	reg irq = 1'b0, wake_n = 1'b1, ext_code = 1'b0, dmove = 1'b0, need = 1'b1, we = 1'b0;
	reg [7:0] addr = 8'h00, wdata = 8'h00;
	reg [3:0] copy_len = 4'h2;
	wire [7:0] rdata, port_init;
	wire [1:0] state;
	wire [2:0] src;
	wire fetch, adv, strobe_n, run, restart, defaults, reload, boot_act, periph, baud, watchdog_load_enable, done;
	integer failures = 0, checks_done = 0, cycles = 0, i, k, nf, na, ns;
	cpu_reset_power_mode_control dut (
		.clk_i(clk_i), .rst_i(rst_i), .async_external_reset_in_i(ext_rst),
		.watchdog_reset_signal_n_i(wdog_n), .watchdog_enabled_i(wdog_en),
		.boot_done_i(done), .irq_pending_i(irq), .ext_irq_low_n_i(wake_n),
		.external_code_i(ext_code), .external_data_move_i(dmove), .insn_need_i(need),
		.sfr_addr_i(addr), .sfr_wdata_i(wdata), .sfr_wr_i(we), .sfr_rdata_o(rdata),
		.state_o(state), .fetch_o(fetch), .fetch_advance_o(adv),
		.program_read_strobe_n_o(strobe_n), .core_run_o(run), .core_restart_o(restart),
		.sfr_defaults_o(defaults), .boot_reload_o(reload), .boot_active_o(boot_act),
		.port_init_o(port_init), .periph_run_o(periph), .baud_doubler_bit_o(baud),
		.watchdog_load_enable_o(watchdog_load_enable), .startup_source_field_o(src)
	);
	boot_partner_model partner (.clk_i(clk_i), .boot_active_i(boot_act),
		.copy_len_i(copy_len), .boot_done_o(done));
	// 20 MHz core clock
	initial
	begin
		forever #25 clk_i = ~clk_i;
	end
	// a hang counts as a mismatch
	always @(posedge clk_i)
	begin
		cycles = cycles + 1;
		if (cycles == 20000)
		begin
			failures = failures + 1;
			results;
		end
	end
	task results;
	begin
		if (failures == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask
	task cmp(input [7:0] got, input [7:0] exp);
	begin
		checks_done = checks_done + 1;
		if (got !== exp)
		begin
			failures = failures + 1;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	end
	endtask
	task wr(input [7:0] a, input [7:0] d);
	begin
		@(negedge clk_i);
		addr = a;
		wdata = d;
		we = 1'b1;
		@(negedge clk_i);
		we = 1'b0;
	end
	endtask
	// read data lags the address by one cycle
	task rd(input [7:0] a, input [7:0] exp);
	begin
		@(negedge clk_i);
		addr = a;
		@(negedge clk_i);
		cmp(rdata, exp);
	end
	endtask
	// short settle first so a pending restart has dropped run
	task wait_run;
	begin
		repeat (2) @(negedge clk_i);
		i = 0;
		while (run !== 1'b1 && i < 300)
		begin
			@(negedge clk_i);
			i = i + 1;
		end
		cmp(run, 8'h01);
	end
	endtask
	// twelve states holding one data move: five fetches go missing
	task count_fetch(input m);
	begin
		ext_code = m;
		need = m;
		nf = 0;
		na = 0;
		ns = 0;
		while (state !== 2'h2) // state output lags, so state zero is live now
			@(negedge clk_i);
		dmove = 1'b1;
		for (i = 0; i < 12; i = i + 1)
		begin
			@(negedge clk_i);
			if (i == 5)
				dmove = 1'b0;
			nf = nf + fetch;
			na = na + adv;
			ns = ns + !strobe_n;
		end
		cmp(nf[7:0], 8'h07);
		cmp(na[7:0], m ? 8'h07 : 8'h00);
		if (m)
			cmp(ns[7:0], 8'h07);
	end
	endtask
	initial
	begin
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		cmp(boot_act, 8'h01);
		wait_run;
		rd(`ADDR_STARTUP_STATUS, 8'h00);
		rd(`ADDR_POWER_CONTROL, `RST_POWER_CONTROL);
		rd(`ADDR_AUX_CONTROL, `RST_AUX_CONTROL);
		rd(`ADDR_BOOT_CONFIG, `RST_BOOT_CONFIG);
		rd(8'h10, 8'h00);
		cmp(port_init, `RST_PORT);
		count_fetch(1'b0);
		count_fetch(1'b1);
		wr(`ADDR_POWER_CONTROL, 8'hEC);
		rd(`ADDR_POWER_CONTROL, 8'h8C);
		cmp(baud, 8'h01);
		wr(`ADDR_POWER_CONTROL, 8'h10);
		@(negedge clk_i);
		cmp(watchdog_load_enable, 8'h01);
		repeat (45) @(negedge clk_i);
		rd(`ADDR_POWER_CONTROL, 8'h00);
		wdog_en = 1'b1;
		wr(`ADDR_POWER_CONTROL, 8'h03);
		rd(`ADDR_POWER_CONTROL, 8'h00);
		wdog_en = 1'b0;
		wr(`ADDR_POWER_CONTROL, 8'h01);
		repeat (2) @(negedge clk_i);
		cmp({periph, strobe_n, run}, 8'h06);
		irq = 1'b1;
		wait_run;
		irq = 1'b0;
		rd(`ADDR_POWER_CONTROL, 8'h00);
		wr(`ADDR_POWER_CONTROL, 8'h03);
		repeat (7) @(negedge clk_i);
		cmp({periph, strobe_n, run}, 8'h00);
		wake_n = 1'b0;
		wait_run;
		wake_n = 1'b1;
		rd(`ADDR_POWER_CONTROL, 8'h00);
		wr(`ADDR_POWER_CONTROL, 8'h0C);
		wr(`ADDR_AUX_CONTROL, 8'h20);
		wait_run;
		rd(`ADDR_POWER_CONTROL, 8'h00);
		rd(`ADDR_AUX_CONTROL, 8'h00);
		rd(`ADDR_STARTUP_STATUS, 8'h01);
		cmp({5'h00, src}, 8'h01);
		copy_len = 4'hC;
		for (k = 0; k < 2; k = k + 1)
		begin
			wr(`ADDR_BOOT_CONFIG, k ? 8'h02 : 8'h00);
			wdog_n = 1'b0;
			repeat (6) @(negedge clk_i);
			wdog_n = 1'b1;
			cmp(boot_act, k[7:0]);
			wait_run;
			rd(`ADDR_STARTUP_STATUS, 8'h02);
			rd(`ADDR_BOOT_CONFIG, 8'h00);
		end
		wr(`ADDR_BOOT_CONFIG, 8'h04);
		wait_run;
		rd(`ADDR_BOOT_CONFIG, 8'h00);
		wr(`ADDR_POWER_CONTROL, 8'h01);
		ext_rst = 1'b1;
		repeat (6) @(negedge clk_i);
		ext_rst = 1'b0;
		cmp(boot_act, 8'h01);
		wait_run;
		rd(`ADDR_POWER_CONTROL, 8'h00);
		rd(`ADDR_STARTUP_STATUS, 8'h00);
		results;
	end
endmodule
